/* File: bench/test_tte_exec.sv */
// Self-checking bench for the transfer, test and wait execution block.
// Assumes rtl/ on the include path and tte_pkg compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "tte_defines.svh"

module test_tte_exec;
	import tte_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	tte_apb_req_t req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq_pending = 1'b0;
	logic ext_reset_req = 1'b0;
	logic [3:0] move_extra_cost = 4'h0;
	logic move_limit = 1'b0;
	logic bus_request_line = 1'b0;
	logic bus_grant_line;
	logic parallel_move_en;
	logic core_clk_en;
	logic mem_clk_en;
	logic periph_clk_en;
	logic osc_clk_en;
	logic exception_start;
	logic exception_is_reset;
	logic [4:0] instr_words;
	int bad_count = 0;
	int cmp_count = 0;
	int n;

	tte_exec dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_pending(irq_pending), .ext_reset_req(ext_reset_req),
		.move_extra_cost(move_extra_cost), .move_limit(move_limit),
		.bus_request_line(bus_request_line),
		.bus_grant_line(bus_grant_line),
		.parallel_move_en(parallel_move_en),
		.core_clk_en(core_clk_en), .mem_clk_en(mem_clk_en),
		.periph_clk_en(periph_clk_en), .osc_clk_en(osc_clk_en),
		.exception_start(exception_start),
		.exception_is_reset(exception_is_reset), .instr_words(instr_words));

	always #4 pclk = ~pclk;

	task automatic stop_test;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// No limit on pready here; the watchdog ends a stuck run
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		req.psel <= 1'b1;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= wd;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] mask);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & mask, exp);
		chk({31'h0, e}, {31'h0, (a > 8'h34 || a[1:0] != 2'h0)});
	endtask

	task automatic wait_idle;
		logic [31:0] s;
		logic e;
		int k;
		k = 0;
		do begin
			apb(1'b0, `TTE_OFF_STATUS, 32'h0, s, e);
			k++;
		end while (s[0] !== 1'b0 && k < 50);
		if (k >= 50) bad_count++;
	endtask

	task automatic wait_exc(output int k);
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (exception_start !== 1'b1 && k < 40);
	endtask

	initial begin
		#200000;
		bad_count++;
		stop_test();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk({core_clk_en, mem_clk_en, periph_clk_en, osc_clk_en}, 32'hF);
		rd_chk(`TTE_OFF_CCR, 32'h0, 32'hFF);
		rd_chk(`TTE_OFF_MR, 32'h0, 32'hFF);
		rd_chk(8'h38, 32'h0, 32'hFFFFFFFF);
		rd_chk(8'h06, 32'h0, 32'hFFFFFFFF);
		// Negative source shows the sign extension into bits 55:48
		wr(`TTE_OFF_X0, 32'h923456);
		move_limit <= 1'b1;
		wr(`TTE_OFF_INSTR, 32'h000041);
		wait_idle();
		move_limit <= 1'b0;
		rd_chk(`TTE_OFF_A_LO, 32'h0, 32'hFFFFFF);
		rd_chk(`TTE_OFF_A_MID, 32'h923456, 32'hFFFFFF);
		rd_chk(`TTE_OFF_A_EXT, 32'hFF, 32'hFF);
		rd_chk(`TTE_OFF_CCR, 32'h40, 32'hFF);
		move_extra_cost <= 4'h2;
		wr(`TTE_OFF_INSTR, 32'hABCD09);
		@(negedge pclk);
		chk({31'h0, parallel_move_en}, 32'h1);
		wait_idle();
		chk({31'h0, parallel_move_en}, 32'h0);
		chk({27'h0, instr_words}, 32'h3);
		rd_chk(`TTE_OFF_B_EXT, 32'hFF, 32'hFF);
		rd_chk(`TTE_OFF_B_MID, 32'h923456, 32'hFFFFFF);
		move_extra_cost <= 4'h0;
		wr(`TTE_OFF_CCR, 32'h02);
		wr(`TTE_OFF_INSTR, 32'h00000B);
		wait_idle();
		rd_chk(`TTE_OFF_CCR, 32'h08, 32'h0E);
		rd_chk(`TTE_OFF_B_MID, 32'h923456, 32'hFFFFFF);
		wr(`TTE_OFF_A_MID, 32'h0);
		wr(`TTE_OFF_A_EXT, 32'h0);
		move_limit <= 1'b1;
		wr(`TTE_OFF_CCR, 32'h0A);
		wr(`TTE_OFF_INSTR, 32'h000003);
		wait_idle();
		move_limit <= 1'b0;
		chk({27'h0, instr_words}, 32'h1);
		rd_chk(`TTE_OFF_CCR, 32'h44, 32'h4E);
		rd_chk(`TTE_OFF_CCR, 32'h50, 32'h70);
		// Same value, other scaling: the reference bits move
		wr(`TTE_OFF_A_MID, 32'h400000);
		wr(`TTE_OFF_MR, 32'h08);
		wr(`TTE_OFF_INSTR, 32'h000003);
		wait_idle();
		rd_chk(`TTE_OFF_CCR, 32'h20, 32'h30);
		wr(`TTE_OFF_MR, 32'h04);
		wr(`TTE_OFF_INSTR, 32'h000003);
		wait_idle();
		rd_chk(`TTE_OFF_CCR, 32'h10, 32'h30);
		wr(`TTE_OFF_MR, 32'h00);
		// Undefined source code runs its cycles but only flags illegal
		wr(`TTE_OFF_INSTR, 32'h000011);
		wait_idle();
		rd_chk(`TTE_OFF_STATUS, 32'h24, 32'h3E7);
		// Wait with nothing pending: clocks gate, grant keeps working
		wr(`TTE_OFF_CCR, 32'h15);
		wr(`TTE_OFF_INSTR, 32'h0000F0);
		repeat (3) @(negedge pclk);
		chk({core_clk_en, mem_clk_en}, 32'h0);
		chk({periph_clk_en, osc_clk_en}, 32'h3);
		@(posedge pclk);
		bus_request_line <= 1'b1;
		repeat (2) @(negedge pclk);
		chk({31'h0, bus_grant_line}, 32'h1);
		@(posedge pclk);
		irq_pending <= 1'b1;
		bus_request_line <= 1'b0;
		wait_exc(n);
		chk({31'h0, n <= 5}, 32'h1);
		chk({31'h0, exception_is_reset}, 32'h0);
		@(posedge pclk);
		irq_pending <= 1'b0;
		wait_idle();
		chk({core_clk_en, mem_clk_en}, 32'h3);
		rd_chk(`TTE_OFF_CCR, 32'h15, 32'hFF);
		wr(`TTE_OFF_INSTR, 32'h0000F0);
		repeat (6) @(negedge pclk);
		@(posedge pclk);
		ext_reset_req <= 1'b1;
		wait_exc(n);
		chk({31'h0, n <= 5}, 32'h1);
		chk({31'h0, exception_is_reset}, 32'h1);
		@(posedge pclk);
		ext_reset_req <= 1'b0;
		wait_idle();
		// Pending interrupt: three idle slots, clocks never gated
		irq_pending <= 1'b1;
		wr(`TTE_OFF_INSTR, 32'h0000F0);
		wait_exc(n);
		chk(32'(n), 32'h4);
		chk({core_clk_en, mem_clk_en}, 32'h3);
		@(posedge pclk);
		irq_pending <= 1'b0;
		wait_idle();
		stop_test();
	end
endmodule // test_tte_exec

`default_nettype wire

/* File: rtl/tte_defines.svh */
// Constants for the transfer, test and wait execution block.
// Assumes inclusion by bare name from the bench and the design file.
`ifndef TTE_DEFINES_SVH
`define TTE_DEFINES_SVH

// APB register byte offsets
`define TTE_OFF_INSTR 8'h00
`define TTE_OFF_STATUS 8'h04
`define TTE_OFF_CCR 8'h08
`define TTE_OFF_MR 8'h0C
`define TTE_OFF_A_LO 8'h10
`define TTE_OFF_A_MID 8'h14
`define TTE_OFF_A_EXT 8'h18
`define TTE_OFF_B_LO 8'h1C
`define TTE_OFF_B_MID 8'h20
`define TTE_OFF_B_EXT 8'h24
`define TTE_OFF_X0 8'h28
`define TTE_OFF_X1 8'h2C
`define TTE_OFF_Y0 8'h30
`define TTE_OFF_Y1 8'h34

// Condition flag bit positions
`define TTE_CCR_C 0
`define TTE_CCR_V 1
`define TTE_CCR_Z 2
`define TTE_CCR_N 3
`define TTE_CCR_U 4
`define TTE_CCR_E 5
`define TTE_CCR_L 6

// Scaling mode field in mr and its codes
`define TTE_MR_SCALE_HI 3
`define TTE_MR_SCALE_LO 2
`define TTE_SCALE_NONE 2'h0
`define TTE_SCALE_DOWN 2'h1
`define TTE_SCALE_UP 2'h2

// Reset values
`define TTE_CCR_RESET 8'h00
`define TTE_MR_RESET 8'h00
`define TTE_ACC_RESET 56'h0
`define TTE_REG_RESET 24'h0

// Opcode patterns of the low byte
`define TTE_TFR_MASK 8'h87
`define TTE_TFR_PAT 8'h01
`define TTE_TST_MASK 8'hF7
`define TTE_TST_PAT 8'h03
// Whole-word code of the wait instruction
`define TTE_OP_WAIT 24'h0000F0

// Timing counts in pclk cycles, base word count and wait exit phase
`define TTE_BASE_CYCLES 5'h02
`define TTE_BASE_WORDS 5'h01
`define TTE_PENDING_NOPS 5'h03
`define TTE_EXIT_PHASE 2'h2

`endif

/* File: rtl/tte_exec.sv */
// Execution logic for register transfer, accumulator test and wait.
// Assumes an APB master on pclk and a parallel-move unit that reports
// its extra cost and limiting; interrupt pending is already masked.
//
// Functional notes
// [RQ1] Transfer copies source to accumulator unshifted, unlimited
// [RQ2] Parallel move runs alongside the transfer
// [RQ3] Transfer changes only the limit flag
// [RQ4] Transfer takes two plus move cycles, words
// [RQ5] Test compares with zero, stores nothing
// [RQ6] Negative flag follows accumulator bit 55
// [RQ7] Zero flag on zero; overflow always cleared
// [RQ8] Extension flag when integer portion in use
// [RQ9] Unnormalized flag when value not normalized
// [RQ10] Extension and unnormalized follow scaling mode
// [RQ11] Test sets limit flag from move limiting
// [RQ12] Test takes two plus move cycles, words
// [RQ13] Wait gates core and memory clocks
// [RQ14] Oscillator and peripheral clocks keep running
// [RQ15] Pending interrupt: wait acts as three nops
// [RQ16] Interrupt or reset ends wait, starts exception
// [RQ17] Bus arbitration keeps working during wait
// [RQ18] Wait always exits in the same phase
// [RQ19] No wait inside fast interrupt routine
// [RQ20] No wait at loop end address
// [RQ21] No wait as repeat target
// [RQ22] Wait leaves condition flags unchanged
// [RQ23] Extra cost equals move words and cycles
// [RQ24] Transfer decoded from low byte 0sssd001
// [RQ25] Test decoded from low byte 0000d011
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tte_defines.svh"

module tte_exec (
	input wire logic pclk,
	input wire logic presetn,
	input wire tte_pkg::tte_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic irq_pending,
	input wire logic ext_reset_req,
	input wire logic [3:0] move_extra_cost,
	input wire logic move_limit,
	input wire logic bus_request_line,
	output logic bus_grant_line,
	output logic parallel_move_en,
	output logic core_clk_en,
	output logic mem_clk_en,
	output logic periph_clk_en,
	output logic osc_clk_en,
	output logic exception_start,
	output logic exception_is_reset,
	output logic [4:0] instr_words
);
	import tte_pkg::*;

	tte_st_t st_r;
	tte_st_t st_nxt;
	logic setup;
	logic wr;
	logic mapped;
	logic is_tfr;
	logic is_tst;
	logic [55:0] src;
	logic [55:0] tacc;

	function automatic logic [55:0] widen(input logic [23:0] v);
		widen = {{8{v[23]}}, v, 24'h000000};
	endfunction

	// Extension: bits above the scaled binary point are not all sign
	function automatic logic ext_flag(input logic [55:0] a,
		input logic [1:0] m);
		case (m)
			`TTE_SCALE_DOWN: ext_flag = !((&a[55:48]) || !(|a[55:48]));
			`TTE_SCALE_UP: ext_flag = !((&a[55:46]) || !(|a[55:46]));
			default: ext_flag = !((&a[55:47]) || !(|a[55:47]));
		endcase
	endfunction

	function automatic logic unnorm_flag(input logic [55:0] a,
		input logic [1:0] m);
		case (m)
			`TTE_SCALE_DOWN: unnorm_flag = !(a[48] ^ a[47]);
			`TTE_SCALE_UP: unnorm_flag = !(a[46] ^ a[45]);
			default: unnorm_flag = !(a[47] ^ a[46]);
		endcase
	endfunction

	assign setup = apb_req.psel && !apb_req.penable;
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign mapped = (apb_req.paddr[1:0] == 2'h0) &&
		(apb_req.paddr <= `TTE_OFF_Y1);
	assign is_tfr = (st_r.op[7:0] & `TTE_TFR_MASK) == `TTE_TFR_PAT; // RQ24
	assign is_tst = (st_r.op[7:0] & `TTE_TST_MASK) == `TTE_TST_PAT; // RQ25

	// Transfer source; code 000 means the other accumulator
	always_comb begin
		case (st_r.op[6:4])
			3'b000: src = st_r.op[3] ? st_r.acc_a : st_r.acc_b; // RQ1
			3'b100: src = widen(st_r.x0);
			3'b110: src = widen(st_r.x1);
			3'b101: src = widen(st_r.y0);
			3'b111: src = widen(st_r.y1);
			default: src = 56'h0;
		endcase
	end
	assign tacc = st_r.op[3] ? st_r.acc_b : st_r.acc_a;

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.exc = 1'b0;
		st_nxt.phase = st_r.phase + 2'h1;
		st_nxt.grant = bus_request_line; // RQ17
		// Read data is caught in the setup cycle so it comes from a flop
		if (setup) begin
			if (apb_req.paddr == `TTE_OFF_INSTR) begin
				st_nxt.rdata = {8'h00, st_r.op};
			end else if (apb_req.paddr == `TTE_OFF_STATUS) begin
				st_nxt.rdata = {22'h0, st_r.words, st_r.phase,
					st_r.illegal, (st_r.fsm == TTE_WAIT),
					(st_r.fsm != TTE_IDLE)};
			end else if (apb_req.paddr == `TTE_OFF_CCR) begin
				st_nxt.rdata = {24'h0, st_r.condition_flags};
			end else if (apb_req.paddr == `TTE_OFF_MR) begin
				st_nxt.rdata = {24'h0, st_r.mr};
			end else if (apb_req.paddr == `TTE_OFF_A_LO) begin
				st_nxt.rdata = {8'h0, st_r.acc_a[23:0]};
			end else if (apb_req.paddr == `TTE_OFF_A_MID) begin
				st_nxt.rdata = {8'h0, st_r.acc_a[47:24]};
			end else if (apb_req.paddr == `TTE_OFF_A_EXT) begin
				st_nxt.rdata = {24'h0, st_r.acc_a[55:48]};
			end else if (apb_req.paddr == `TTE_OFF_B_LO) begin
				st_nxt.rdata = {8'h0, st_r.acc_b[23:0]};
			end else if (apb_req.paddr == `TTE_OFF_B_MID) begin
				st_nxt.rdata = {8'h0, st_r.acc_b[47:24]};
			end else if (apb_req.paddr == `TTE_OFF_B_EXT) begin
				st_nxt.rdata = {24'h0, st_r.acc_b[55:48]};
			end else if (apb_req.paddr == `TTE_OFF_X0) begin
				st_nxt.rdata = {8'h0, st_r.x0};
			end else if (apb_req.paddr == `TTE_OFF_X1) begin
				st_nxt.rdata = {8'h0, st_r.x1};
			end else if (apb_req.paddr == `TTE_OFF_Y0) begin
				st_nxt.rdata = {8'h0, st_r.y0};
			end else if (apb_req.paddr == `TTE_OFF_Y1) begin
				st_nxt.rdata = {8'h0, st_r.y1};
			end else begin
				st_nxt.rdata = 32'h0;
			end
		end
		// Software may touch operands only while no instruction runs
		if (wr && st_r.fsm == TTE_IDLE) begin
			if (apb_req.paddr == `TTE_OFF_INSTR) begin
				st_nxt.op = apb_req.pwdata[23:0];
				st_nxt.mv = move_extra_cost;
				st_nxt.illegal = 1'b0;
				if (apb_req.pwdata[23:0] == `TTE_OP_WAIT) begin
					st_nxt.words = `TTE_BASE_WORDS;
					if (irq_pending) begin
						st_nxt.fsm = TTE_NOPS; // RQ15
						st_nxt.cnt = `TTE_PENDING_NOPS - 5'h01;
					end else begin
						st_nxt.fsm = TTE_WAIT; // RQ13
					end
				end else begin
					st_nxt.fsm = TTE_EXEC;
					// RQ4 RQ12 RQ23
					st_nxt.cnt = `TTE_BASE_CYCLES + {1'b0, move_extra_cost}
						- 5'h01;
					st_nxt.words = `TTE_BASE_WORDS + {1'b0, move_extra_cost};
				end
			end else if (apb_req.paddr == `TTE_OFF_CCR) begin
				st_nxt.condition_flags = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `TTE_OFF_A_LO) begin
				st_nxt.acc_a[23:0] = apb_req.pwdata[23:0];
			end else if (apb_req.paddr == `TTE_OFF_A_MID) begin
				st_nxt.acc_a[47:24] = apb_req.pwdata[23:0];
			end else if (apb_req.paddr == `TTE_OFF_A_EXT) begin
				st_nxt.acc_a[55:48] = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `TTE_OFF_B_LO) begin
				st_nxt.acc_b[23:0] = apb_req.pwdata[23:0];
			end else if (apb_req.paddr == `TTE_OFF_B_MID) begin
				st_nxt.acc_b[47:24] = apb_req.pwdata[23:0];
			end else if (apb_req.paddr == `TTE_OFF_B_EXT) begin
				st_nxt.acc_b[55:48] = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `TTE_OFF_X0) begin
				st_nxt.x0 = apb_req.pwdata[23:0];
			end else if (apb_req.paddr == `TTE_OFF_X1) begin
				st_nxt.x1 = apb_req.pwdata[23:0];
			end else if (apb_req.paddr == `TTE_OFF_Y0) begin
				st_nxt.y0 = apb_req.pwdata[23:0];
			end else if (apb_req.paddr == `TTE_OFF_Y1) begin
				st_nxt.y1 = apb_req.pwdata[23:0];
			end
		end
		// Scaling mode may change at any time
		if (wr && apb_req.paddr == `TTE_OFF_MR) begin
			st_nxt.mr = apb_req.pwdata[7:0];
		end
		case (st_r.fsm)
			TTE_EXEC: begin
				if (st_r.cnt != 5'h00) begin
					st_nxt.cnt = st_r.cnt - 5'h01;
				end else begin
					st_nxt.fsm = TTE_IDLE;
					st_nxt.done = 1'b1;
					if (is_tfr && (st_r.op[6:4] == 3'b000 || st_r.op[6])) begin
						if (st_r.op[3]) begin
							st_nxt.acc_b = src; // RQ1
						end else begin
							st_nxt.acc_a = src;
						end
						st_nxt.condition_flags[`TTE_CCR_L] = st_r.condition_flags[`TTE_CCR_L] ||
							move_limit; // RQ3
					end else if (is_tst) begin
						// Accumulators untouched; only flags change
						st_nxt.condition_flags[`TTE_CCR_N] = tacc[55]; // RQ5 RQ6
						st_nxt.condition_flags[`TTE_CCR_Z] = (tacc == 56'h0); // RQ7
						st_nxt.condition_flags[`TTE_CCR_V] = 1'b0; // RQ7
						// RQ8 RQ10
						st_nxt.condition_flags[`TTE_CCR_E] = ext_flag(tacc,
							st_r.mr[`TTE_MR_SCALE_HI:`TTE_MR_SCALE_LO]);
						// RQ9 RQ10
						st_nxt.condition_flags[`TTE_CCR_U] = unnorm_flag(tacc,
							st_r.mr[`TTE_MR_SCALE_HI:`TTE_MR_SCALE_LO]);
						st_nxt.condition_flags[`TTE_CCR_L] = st_r.condition_flags[`TTE_CCR_L] ||
							move_limit; // RQ11
					end else begin
						st_nxt.illegal = 1'b1;
					end
				end
			end
			TTE_NOPS: begin
				if (st_r.cnt != 5'h00) begin
					st_nxt.cnt = st_r.cnt - 5'h01;
				end else begin
					st_nxt.fsm = TTE_IDLE;
					st_nxt.exc = 1'b1; // RQ15
					st_nxt.exc_rst = 1'b0;
				end
			end
			TTE_WAIT: begin // RQ22
				// Common exit phase keeps several woken cores in step
				if ((irq_pending || ext_reset_req) &&
					st_r.phase == `TTE_EXIT_PHASE) begin // RQ18
					st_nxt.fsm = TTE_IDLE; // RQ16
					st_nxt.exc = 1'b1;
					st_nxt.exc_rst = ext_reset_req;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{fsm: TTE_IDLE, cnt: 5'h00, op: 24'h000000, mv: 4'h0,
				acc_a: `TTE_ACC_RESET, acc_b: `TTE_ACC_RESET,
				x0: `TTE_REG_RESET, x1: `TTE_REG_RESET,
				y0: `TTE_REG_RESET, y1: `TTE_REG_RESET,
				condition_flags: `TTE_CCR_RESET, mr: `TTE_MR_RESET, phase: 2'h0,
				grant: 1'b0, done: 1'b0, exc: 1'b0, exc_rst: 1'b0,
				illegal: 1'b0, words: 5'h00, rdata: 32'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.rdata;
	assign pready = 1'b1;
	assign pslverr = apb_req.psel && apb_req.penable && !mapped;
	assign bus_grant_line = st_r.grant;
	assign parallel_move_en = (st_r.fsm == TTE_EXEC); // RQ2
	assign core_clk_en = (st_r.fsm != TTE_WAIT); // RQ13
	assign mem_clk_en = (st_r.fsm != TTE_WAIT);
	assign periph_clk_en = 1'b1; // RQ14
	assign osc_clk_en = 1'b1;
	assign exception_start = st_r.exc;
	assign exception_is_reset = st_r.exc_rst;
	assign instr_words = st_r.words;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [5:0] age_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_r <= 6'h00;
		end else if (wr && st_r.fsm == TTE_IDLE &&
			apb_req.paddr == `TTE_OFF_INSTR) begin
			age_r <= 6'h00;
		end else if (age_r != 6'h3F) begin
			age_r <= age_r + 6'h01;
		end
	end

	property p_exec_time;
		st_r.done |-> age_r == {2'b00, st_r.mv} + 6'h02;
	endproperty
	a_exec_time: assert property (p_exec_time) // RQ4
		else $error("execution length wrong");

	property p_tfr_flags;
		st_r.done && $past(is_tfr) |->
			st_r.condition_flags[5:0] == $past(st_r.condition_flags[5:0]);
	endproperty
	a_tfr_flags: assert property (p_tfr_flags) // RQ3
		else $error("transfer changed flags");

	property p_tst_keep;
		st_r.done && $past(is_tst) |->
			$stable(st_r.acc_a) && $stable(st_r.acc_b);
	endproperty
	a_tst_keep: assert property (p_tst_keep) // RQ5
		else $error("test altered accumulator");

	property p_tst_nzv;
		st_r.done && $past(is_tst) |->
			st_r.condition_flags[`TTE_CCR_N] == tacc[55] && !st_r.condition_flags[`TTE_CCR_V] &&
			st_r.condition_flags[`TTE_CCR_Z] == (tacc == 56'h0);
	endproperty
	a_tst_nzv: assert property (p_tst_nzv) // RQ7
		else $error("test flags wrong");

	property p_wait_gate;
		st_r.fsm == TTE_WAIT |-> !core_clk_en && !mem_clk_en &&
			periph_clk_en && $stable(st_r.condition_flags);
	endproperty
	a_wait_gate: assert property (p_wait_gate) // RQ13
		else $error("clocks or flags wrong in wait");

	property p_exit_phase;
		$past(st_r.fsm) == TTE_WAIT && st_r.fsm == TTE_IDLE |->
			st_r.exc && st_r.phase == `TTE_EXIT_PHASE + 2'h1;
	endproperty
	a_exit_phase: assert property (p_exit_phase) // RQ18
		else $error("wait left in wrong phase");

	property p_nops;
		st_r.fsm == TTE_IDLE ##1 st_r.fsm == TTE_NOPS |->
			st_r.fsm == TTE_NOPS [*3] ##1 st_r.exc;
	endproperty
	a_nops: assert property (p_nops) // RQ15
		else $error("pending wait not three nops");

	property p_grant;
		bus_request_line |=> bus_grant_line;
	endproperty
	a_grant: assert property (p_grant) // RQ17
		else $error("grant missing");

	property p_grant_drop;
		!bus_request_line |=> !bus_grant_line;
	endproperty
	a_grant_drop: assert property (p_grant_drop) // RQ17
		else $error("grant held without request");

	// Low byte 09 moves A into B whole, sign byte included
	property p_tfr_acc;
		st_r.done && st_r.op[7:0] == 8'h09 |->
			st_r.acc_b == $past(st_r.acc_a);
	endproperty
	a_tfr_acc: assert property (p_tfr_acc) // RQ1
		else $error("transfer did not copy accumulator");

	property p_tst_limit;
		st_r.done && $past(is_tst) && $past(move_limit) |->
			st_r.condition_flags[`TTE_CCR_L];
	endproperty
	a_tst_limit: assert property (p_tst_limit) // RQ11
		else $error("limit flag not set by test");

	property p_wake;
		st_r.fsm == TTE_WAIT && irq_pending |-> ##[1:4] st_r.exc;
	endproperty
	a_wake: assert property (p_wake) // RQ16
		else $error("wait not left on interrupt");

endmodule // tte_exec
`default_nettype wire

/* File: rtl/tte_pkg.sv */
// Types for the transfer, test and wait execution block.
// Assumes tte_defines.svh is on the include path.
package tte_pkg;

	typedef enum logic [1:0] {
		TTE_IDLE = 2'b00,
		TTE_EXEC = 2'b01,
		TTE_WAIT = 2'b10,
		TTE_NOPS = 2'b11
	} tte_fsm_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} tte_apb_req_t;

	typedef struct packed {
		tte_fsm_t fsm;
		logic [4:0] cnt;
		logic [23:0] op;
		logic [3:0] mv;
		logic [55:0] acc_a;
		logic [55:0] acc_b;
		logic [23:0] x0;
		logic [23:0] x1;
		logic [23:0] y0;
		logic [23:0] y1;
		logic [7:0] condition_flags;
		logic [7:0] mr;
		logic [1:0] phase;
		logic grant;
		logic done;
		logic exc;
		logic exc_rst;
		logic illegal;
		logic [4:0] words;
		logic [31:0] rdata;
	} tte_st_t;

endpackage
